/* File: rtl/bcs_pkg.sv */
// Package for the boot configuration script interpreter.
// Assumes a single 200 MHz clock domain shared by all users.
package bcs_pkg;

  // ----------------------------------------------------------------
  // Script geometry
  // ----------------------------------------------------------------
  localparam int unsigned SCRIPT_WORDS = 60;
  localparam int unsigned SCRIPT_BYTES = 240;
  localparam logic [5:0] LAST_WORD_IDX = 6'h3B;
  localparam logic [31:0] SCRIPT_BASE_ADDR = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Entry encodings
  // ----------------------------------------------------------------
  localparam logic [31:0] START_MARKER = 32'hA5A5A5A5;
  localparam logic [31:0] DEBUG_DISABLE_CMD = 32'h70000000;
  localparam logic [31:0] SPI_FAST_CMD = 32'hA0000000;
  localparam logic [31:0] ERASED_WORD = 32'h0FFFFFFF;
  localparam logic [31:0] ERASED_FULL = 32'hFFFFFFFF;
  localparam logic [15:0] CAL_TAG = 16'h9000;
  localparam logic [3:0] TIMEOUT_NIBBLE = 4'h8;
  localparam int unsigned CAL_COUNT_LSB = 8;
  localparam int unsigned CAL_INDEX_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [27:0] TIMEOUT_RESET = 28'h0000000;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TIMEOUT_UNIT_US = 100;
  localparam int unsigned TIMEOUT_UNIT_CYC = TIMEOUT_UNIT_US * CLK_MHZ;
  localparam int unsigned SPI_SLOW_MHZ = 2;
  localparam int unsigned SPI_FAST_MHZ = 32;

  typedef struct packed {
    logic [27:0] uart_start_char_timeout;
    logic timeout_set;
    logic spi_fast;
    logic debug_disable;
    logic script_valid;
  } bcs_cfg_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } bcs_wr_t;

endpackage : bcs_pkg

/* File: rtl/bcs_interp.sv */
// Boot configuration script interpreter: walks OTP words, applies entries.
// Assumes an OTP read port with request/valid and a single-beat bus writer.
//
// Function
// [RULE1] Script is at most 60 words, 240 bytes; never read past the last.
// [RULE2] Script valid only if the first word is the start marker.
// [RULE3] Address word then data word; write data to that address.
// [RULE4] Calibration header 0x9000YYXX: following words are never written.
// [RULE5] Header bits 15:8 give how many words to skip next.
// [RULE6] Header low byte is a rising index, constant within one value.
// [RULE7] Debug-disable entry recorded: port stays disabled, no idle loop.
// [RULE8] With debug-disable and no boot source, rescan peripherals.
// [RULE9] Top nibble 8 sets start-char timeout in 100 us units.
// [RULE10] Fast-SPI entry switches boot SPI clock from 2 MHz to 32 MHz.
// [RULE11] First erased word ends processing; later words ignored.
// [RULE12] Processing completes before the processor is released.
// [RULE13] New entries may be appended into erased words to patch old ones.
// [RULE14] Bad start marker: skip whole script, no writes, signal done.
module bcs_interp
  import bcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  output logic otp_req,
  output logic [31:0] otp_addr,
  input wire logic otp_valid,
  input wire logic [31:0] otp_rdata,
  output logic bus_wr_valid,
  output bcs_wr_t bus_wr,
  input wire logic bus_wr_ready,
  input wire logic no_boot_source,
  output bcs_cfg_t cfg,
  output logic cpu_release,
  output logic rescan,
  output logic debug_enable,
  output logic done
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_WAIT, ST_DECODE, ST_WRITE, ST_DONE
  } bcs_state_t;

  bcs_state_t state_q, state_d;
  logic [5:0] idx_q, idx_d;
  logic [31:0] word_q, word_d;
  logic [7:0] skip_q, skip_d;
  logic addr_phase_q, addr_phase_d;
  bcs_wr_t wr_q, wr_d;
  bcs_cfg_t cfg_q, cfg_d;
  logic done_q, done_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic first_word = (idx_q == 6'h00);
  wire logic last_word = (idx_q == LAST_WORD_IDX);
  wire logic is_erased = (word_q == ERASED_WORD) || (word_q == ERASED_FULL);
  wire logic is_start = (word_q == START_MARKER);
  wire logic is_cal = (word_q[31:16] == CAL_TAG);
  wire logic is_dbg = (word_q == DEBUG_DISABLE_CMD);
  wire logic is_spi = (word_q == SPI_FAST_CMD);
  wire logic is_tmo = (word_q[31:28] == TIMEOUT_NIBBLE);
  wire logic [7:0] cal_count = word_q[CAL_COUNT_LSB +: 8];
  // Calibration index bits are left to software; nothing here reads them
  wire logic [5:0] idx_inc = idx_q + 6'h01;

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    word_d = word_q;
    skip_d = skip_q;
    addr_phase_d = addr_phase_q;
    wr_d = wr_q;
    cfg_d = cfg_q;
    done_d = done_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          idx_d = 6'h00;
          skip_d = 8'h00;
          addr_phase_d = 1'b0;
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (otp_valid) begin
          word_d = otp_rdata;
          state_d = ST_DECODE;
        end
      end
      ST_DECODE: begin
        state_d = ST_READ;
        if (first_word) begin
          if (is_start) begin
            cfg_d.script_valid = 1'b1; // RULE2
          end else begin
            state_d = ST_DONE; // RULE14
          end
        end else if (addr_phase_q) begin
          wr_d.data = word_q; // RULE3
          addr_phase_d = 1'b0;
          state_d = ST_WRITE;
        end else if (skip_q != 8'h00) begin
          skip_d = skip_q - 8'h01; // RULE4
        end else if (is_erased) begin
          state_d = ST_DONE; // RULE11
        end else if (is_cal) begin
          skip_d = cal_count; // RULE5
        end else if (is_dbg) begin
          cfg_d.debug_disable = 1'b1; // RULE7
        end else if (is_spi) begin
          cfg_d.spi_fast = 1'b1; // RULE10
        end else if (is_tmo) begin
          cfg_d.uart_start_char_timeout = word_q[27:0]; // RULE9
          cfg_d.timeout_set = 1'b1;
        end else begin
          wr_d.addr = word_q; // RULE3
          addr_phase_d = 1'b1;
        end
        // Hard stop at the end of the array even mid-entry
        if (state_d == ST_READ) begin
          if (last_word) begin
            state_d = ST_DONE; // RULE1
          end else begin
            idx_d = idx_inc;
          end
        end
      end
      ST_WRITE: begin
        if (bus_wr_ready) begin
          if (last_word) begin
            state_d = ST_DONE; // RULE1
          end else begin
            idx_d = idx_inc;
            state_d = ST_READ;
          end
        end
      end
      ST_DONE: begin
        done_d = 1'b1; // RULE12
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      idx_q <= 6'h00;
      word_q <= 32'h00000000;
      skip_q <= 8'h00;
      addr_phase_q <= 1'b0;
      wr_q <= '0;
      cfg_q <= '{uart_start_char_timeout: TIMEOUT_RESET, default: 1'b0};
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      word_q <= word_d;
      skip_q <= skip_d;
      addr_phase_q <= addr_phase_d;
      wr_q <= wr_d;
      cfg_q <= cfg_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Word address stays inside the array since idx never passes the last word
  assign otp_req = (state_q == ST_READ); // RULE1
  assign otp_addr = SCRIPT_BASE_ADDR + {24'h000000, idx_q, 2'b00};
  assign bus_wr_valid = (state_q == ST_WRITE); // RULE3
  assign bus_wr = wr_q;
  assign cfg = cfg_q;
  assign done = done_q;
  assign cpu_release = done_q; // RULE12
  // Debug port only opens when no disable entry was seen
  assign debug_enable = done_q && !cfg_q.debug_disable && no_boot_source; // RULE7
  assign rescan = done_q && cfg_q.debug_disable && no_boot_source; // RULE8

endmodule // bcs_interp

/* File: bench/bcs_otp_mdl.sv */
// OTP array model: answers each read after a short or a long wait.
// Assumes the bench loads mem directly while each reset is held.
module bcs_otp_mdl (
  input wire logic ref_clk,
  input wire logic otp_req,
  input wire logic [31:0] otp_addr,
  input wire logic slow,
  output logic otp_valid,
  output logic [31:0] otp_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [60];
  logic [5:0] a_q;
  int wait_q = -1;
  initial begin
    otp_valid = 1'b0;
    otp_rdata = 32'h0;
  end
  // Idle data flips every cycle so stale words are never mistaken
  always @(posedge ref_clk) begin
    otp_valid <= 1'b0;
    otp_rdata <= ~otp_rdata;
    wait_q <= wait_q - 1;
    if (otp_req) begin
      a_q <= otp_addr[7:2];
      wait_q <= slow ? 4 : 0;
    end else if (wait_q == 0) begin
      otp_valid <= 1'b1;
      otp_rdata <= mem[a_q];
    end
  end
endmodule // bcs_otp_mdl

/* File: bench/bcs_interp_chk.sv */
// Port checker for the script interpreter.
// Assumes one clock domain; bound from the bench top file.
module bcs_interp_chk
  import bcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic otp_req,
  input wire logic [31:0] otp_addr,
  input wire logic bus_wr_valid,
  input wire bcs_wr_t bus_wr,
  input wire logic bus_wr_ready,
  input wire logic no_boot_source,
  input wire bcs_cfg_t cfg,
  input wire logic cpu_release,
  input wire logic rescan,
  input wire logic debug_enable,
  input wire logic done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_stall;
    bus_wr_valid && !bus_wr_ready;
  endsequence
  a_addr_range: assert property (otp_req |-> otp_addr <= 32'hEC && otp_addr[1:0] == 2'h0)
    else $error("otp address out of range");
  a_marker_gate: assert property (otp_req && otp_addr != 32'h0 |-> cfg.script_valid)
    else $error("read past start word without marker");
  a_bad_quiet: assert property (!cfg.script_valid |-> !bus_wr_valid && cfg == '0)
    else $error("activity without valid script");
  a_wr_hold: assert property (s_stall |=> bus_wr_valid && $stable(bus_wr))
    else $error("write dropped or changed while stalled");
  a_done_hold: assert property (done |=> done && cpu_release && $stable(cfg))
    else $error("state moved after done");
  a_done_idle: assert property (done |-> !otp_req && !bus_wr_valid)
    else $error("traffic after done");
  a_rescan_map: assert property (rescan == (done && cfg.debug_disable && no_boot_source))
    else $error("rescan wrong");
  a_debug_map: assert property (debug_enable == (done && !cfg.debug_disable && no_boot_source))
    else $error("debug enable wrong");
endmodule // bcs_interp_chk

/* File: bench/bcs_interp_test.sv */
// Random script bench for the interpreter, one reset per script.
// Assumes the OTP model and the port checker beside it.
module bcs_interp_test
  import bcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_b = 0, start = 0, bus_wr_ready = 0, no_boot_source = 0, slow = 0;
  logic otp_req, otp_valid, bus_wr_valid, cpu_release, rescan, debug_enable, done;
  logic [31:0] otp_addr, otp_rdata, r, w, s = 32'hD3715C05;
  logic [7:0] idx;
  bcs_wr_t bus_wr;
  bcs_wr_t exp_q[$], got_q[$];
  bcs_cfg_t cfg, exp_cfg;
  int n_fail = 0, checked = 0, cyc = 0, t, i, n, stop;
  always #2.5 ref_clk = ~ref_clk;
  bcs_interp i_dut (.*);
  bcs_otp_mdl i_otp (.*);
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Walks the loaded script the way the interpreter should
  task automatic predict();
    int j;
    logic [31:0] v;
    exp_q = {};
    exp_cfg = '0;
    if (i_otp.mem[0] !== START_MARKER) return;
    exp_cfg.script_valid = 1'b1;
    for (j = 1; j < 60; j++) begin
      v = i_otp.mem[j];
      if (v === ERASED_WORD || v === ERASED_FULL) break;
      if (v[31:16] === CAL_TAG) j += v[15:8];
      else if (v === DEBUG_DISABLE_CMD) exp_cfg.debug_disable = 1'b1;
      else if (v === SPI_FAST_CMD) exp_cfg.spi_fast = 1'b1;
      else if (v[31:28] === TIMEOUT_NIBBLE) exp_cfg[31:3] = {v[27:0], 1'b1};
      else if (j < 59) exp_q.push_back({v, i_otp.mem[++j]});
    end
  endtask
  always @(negedge ref_clk) bus_wr_ready <= rnd() % 3 != 0;
  always @(posedge ref_clk) begin
    if (bus_wr_valid && bus_wr_ready) got_q.push_back(bus_wr);
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    for (t = 0; t < 6; t++) begin
      rst_b = 0;
      start = 0;
      slow = t[0];
      no_boot_source = t[1];
      stop = t < 2 ? 99 : 12 * t;
      idx = 8'h01;
      i_otp.mem[0] = t == 1 ? rnd() & 32'h7FFFFFFF : START_MARKER;
      for (i = 1; i < 60; i++) begin
        r = rnd();
        case (r[2:0])
          3'h0: w = SPI_FAST_CMD;
          3'h1: w = DEBUG_DISABLE_CMD;
          3'h2: w = {TIMEOUT_NIBBLE, r[31:4]};
          3'h3: w = {CAL_TAG, 6'h0, r[4:3], idx};
          default: w = {4'h4, r[31:4]};
        endcase
        n = r[2:0] == 3'h3 ? r[4:3] : r[2:0] > 3'h3;
        if (r[2:0] == 3'h3) idx++;
        if (i >= stop) begin
          w = r[5] ? ERASED_WORD : ERASED_FULL;
          stop = 99;
        end
        i_otp.mem[i] = w;
        repeat (n) if (i < 59) i_otp.mem[++i] = rnd();
      end
      predict();
      repeat (5) @(negedge ref_clk);
      got_q = {};
      rst_b = 1;
      @(negedge ref_clk);
      start = 1;
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
        @(negedge ref_clk);
        n++;
      end
      chk("writes", exp_q.size(), got_q.size());
      foreach (exp_q[k]) if (k < got_q.size()) chk("write", exp_q[k], got_q[k]);
      chk("cfg", exp_cfg, cfg);
      chk("done", 2'h3, {done, cpu_release});
      chk("dbg", {exp_cfg.debug_disable & t[1], ~exp_cfg.debug_disable & t[1]},
        {rescan, debug_enable});
      $display("test %0d ends, n_fail %0d", t, n_fail);
    end
    complete_run();
  end
endmodule // bcs_interp_test
bind bcs_interp bcs_interp_chk i_chk (.*);
